// ==== shared/pdci_pkg.sv ====
// Constants for the port data and change interrupt block
package pdci_pkg;
   localparam int PORT_W = 8;
   // Register select codes on the local register port
   localparam logic [3:0] REG_PIN_DIR     = 4'h0;
   localparam logic [3:0] REG_IRQ_EN      = 4'h1;
   localparam logic [3:0] REG_DEF_VAL     = 4'h2;
   localparam logic [3:0] REG_CMP_SRC     = 4'h3;
   localparam logic [3:0] REG_CONFIG      = 4'h4;
   localparam logic [3:0] REG_SRC_FLAGS   = 4'h5;
   localparam logic [3:0] REG_CAPTURE     = 4'h6;
   localparam logic [3:0] REG_PIN_VALUE   = 4'h7;
   localparam logic [3:0] REG_OUT_LATCH   = 4'h8;
   // Configuration bit positions
   localparam int CFG_COMBINE    = 6;
   localparam int CFG_OPEN_DRAIN = 2;
   localparam int CFG_POLARITY   = 1;
   localparam int CFG_CLEAR_SEL  = 0;
   localparam logic [7:0] CFG_MASK    = 8'h47;
   // Reset values
   localparam logic [7:0] RST_DIR     = 8'hFF;
   localparam logic [7:0] RST_ZERO    = 8'h00;
endpackage : pdci_pkg

// ==== src/pdci_top.sv ====
// Port data, output latch and change interrupt logic for two 8-bit ports
//
// Function
// - Capture register holds pin levels at interrupt
// - Port read returns sampled pin levels
// - Port write updates the output latch
// - Latch read returns latch contents
// - Latch drives pin only when output
// - Only enabled inputs can raise interrupts
// - Output pins never affect interrupt outputs
// - One independent interrupt signal per port
// - Separate mode routes each port alone
// - Combined mode ORs both port interrupts
// - Combined mode clears per port read
// - Previous-value mode interrupts on pin change
// - Default mode interrupts on default mismatch
// - Outputs selectable low, high or open-drain
// - Interrupt copies port pins into capture
// - Pending interrupt blocks new capture
// - Only selected register read clears interrupt
// - Clear happens after last data bit
// - Pending change reasserts after port read
// - New level becomes previous-value reference
// - Default mismatch persists after clearing read
// - Clear-select picks capture or port read
// - Open-drain overrides polarity bit
// - Compare-source bit picks default or previous
// - Source flags mark pins that interrupted
`timescale 1ns/1ps
module pdci_top
   import pdci_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              CLK_EN,
   // Register port from the serial front end
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   input  wire logic              REG_RD_DONE,
   input  wire logic              REG_PORT_B,
   input  wire logic [3:0]        REG_SEL,
   input  wire logic [7:0]        REG_WDATA,
   output logic      [7:0]        REG_RDATA,
   // Port pins
   input  wire logic [7:0]        PORT_A_PINS_IN,
   input  wire logic [7:0]        PORT_B_PINS_IN,
   output logic      [7:0]        PORT_A_PINS_OUT,
   output logic      [7:0]        PORT_A_PINS_OE,
   output logic      [7:0]        PORT_B_PINS_OUT,
   output logic      [7:0]        PORT_B_PINS_OE,
   // Interrupt outputs
   output logic                   IRQ_OUT_A_OUT,
   output logic                   IRQ_OUT_A_OE,
   output logic                   IRQ_OUT_B_OUT,
   output logic                   IRQ_OUT_B_OE
);

   logic [7:0] expander_config_ff;
   logic [7:0] pin_dir_ff       [2];
   logic [7:0] irq_en_ff        [2];
   logic [7:0] def_val_ff       [2];
   logic [7:0] cmp_src_ff       [2];
   logic [7:0] latch_ff         [2];
   logic [7:0] capture_ff       [2];
   logic [7:0] flags_ff         [2];
   logic [7:0] prev_ff          [2];
   logic       pend_ff          [2];
   logic       clr_arm_ff       [2];
   logic [7:0] pins             [2];
   logic [7:0] mismatch         [2];
   logic       clr_now          [2];
   logic       irq_a;
   logic       irq_b;
   logic       sel_p;

   assign pins[0] = PORT_A_PINS_IN;
   assign pins[1] = PORT_B_PINS_IN;
   assign sel_p   = REG_PORT_B;

   // Pin compare, both reference sources per bit, gated to enabled inputs
   function automatic logic [7:0] change_detect(input logic [7:0] pv, input logic [7:0] ref_prev,
                                                input logic [7:0] dv, input logic [7:0] src,
                                                input logic [7:0] en, input logic [7:0] dir);
      change_detect = ((src & (pv ^ dv)) | (~src & (pv ^ ref_prev)))
                      & en & dir;
   endfunction : change_detect

   // Clearing read matches the clear-select bit
   function automatic logic is_clear_reg(input logic [3:0] sel, input logic cs);
      is_clear_reg = cs ? (sel == REG_CAPTURE) : (sel == REG_PIN_VALUE);
   endfunction : is_clear_reg

   // Configuration register is shared by both ports
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         expander_config_ff <= RST_ZERO;
      end else if (CLK_EN && REG_WR && REG_SEL == REG_CONFIG) begin
         expander_config_ff <= REG_WDATA & CFG_MASK;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_port
      assign mismatch[p] = change_detect(pins[p], prev_ff[p], def_val_ff[p], cmp_src_ff[p],
                                         irq_en_ff[p], pin_dir_ff[p]);
      // Clear lands only when the front end reports the last bit shifted out
      assign clr_now[p]  = clr_arm_ff[p] && REG_RD_DONE;

      // Software configuration and latch
      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            pin_dir_ff[p] <= RST_DIR;
            irq_en_ff[p]  <= RST_ZERO;
            def_val_ff[p] <= RST_ZERO;
            cmp_src_ff[p] <= RST_ZERO;
            latch_ff[p]   <= RST_ZERO;
         end else if (CLK_EN && REG_WR && (sel_p == 1'(p))) begin
            unique case (REG_SEL)
               REG_PIN_DIR:   pin_dir_ff[p] <= REG_WDATA;
               REG_IRQ_EN:    irq_en_ff[p]  <= REG_WDATA;
               REG_DEF_VAL:   def_val_ff[p] <= REG_WDATA;
               REG_CMP_SRC:   cmp_src_ff[p] <= REG_WDATA;
               REG_PIN_VALUE,
               REG_OUT_LATCH: latch_ff[p]   <= REG_WDATA;
               default:       ;
            endcase
         end
      end

      // Arm clear on a qualifying read; writes never arm it
      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            clr_arm_ff[p] <= 1'b0;
         end else if (CLK_EN) begin
            if (REG_RD && sel_p == 1'(p) &&
                is_clear_reg(REG_SEL, expander_config_ff[CFG_CLEAR_SEL])) begin
               clr_arm_ff[p] <= 1'b1;
            end else if (REG_RD_DONE) begin
               clr_arm_ff[p] <= 1'b0;
            end
         end
      end

      // Pending flag, capture and source flags; a new condition wins over clear
      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            pend_ff[p]    <= 1'b0;
            capture_ff[p] <= RST_ZERO;
            flags_ff[p]   <= RST_ZERO;
            prev_ff[p]    <= RST_ZERO;
         end else if (CLK_EN) begin
            if ((!pend_ff[p] || clr_now[p]) && (mismatch[p] != RST_ZERO)) begin
               pend_ff[p]    <= 1'b1;
               capture_ff[p] <= pins[p];
               flags_ff[p]   <= mismatch[p];
               prev_ff[p]    <= pins[p];
            end else if (clr_now[p]) begin
               pend_ff[p]    <= 1'b0;
               flags_ff[p]   <= RST_ZERO;
               prev_ff[p]    <= pins[p];
            end else if (!pend_ff[p]) begin
               prev_ff[p]    <= pins[p];
            end
            // While pending, capture and reference are held
         end
      end
   end

   // Read data is registered
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= RST_ZERO;
      end else if (CLK_EN && REG_RD) begin
         unique case (REG_SEL)
            REG_PIN_DIR:   REG_RDATA <= pin_dir_ff[sel_p];
            REG_IRQ_EN:    REG_RDATA <= irq_en_ff[sel_p];
            REG_DEF_VAL:   REG_RDATA <= def_val_ff[sel_p];
            REG_CMP_SRC:   REG_RDATA <= cmp_src_ff[sel_p];
            REG_CONFIG:    REG_RDATA <= expander_config_ff;
            REG_SRC_FLAGS: REG_RDATA <= flags_ff[sel_p];
            REG_CAPTURE:   REG_RDATA <= capture_ff[sel_p];
            REG_PIN_VALUE: REG_RDATA <= pins[sel_p];
            REG_OUT_LATCH: REG_RDATA <= latch_ff[sel_p];
            default:       REG_RDATA <= RST_ZERO;
         endcase
      end
   end

   // Pins: latch drives only output-configured pins
   assign PORT_A_PINS_OUT = latch_ff[0];
   assign PORT_A_PINS_OE  = ~pin_dir_ff[0];
   assign PORT_B_PINS_OUT = latch_ff[1];
   assign PORT_B_PINS_OE  = ~pin_dir_ff[1];

   // Routing; combined mode still needs both ports cleared
   assign irq_a = expander_config_ff[CFG_COMBINE] ? (pend_ff[0] | pend_ff[1])
                                                  : pend_ff[0];
   assign irq_b = expander_config_ff[CFG_COMBINE] ? (pend_ff[0] | pend_ff[1])
                                                  : pend_ff[1];

   // Open drain pulls low when active and releases otherwise
   always_comb begin
      if (expander_config_ff[CFG_OPEN_DRAIN]) begin
         IRQ_OUT_A_OUT = 1'b0;
         IRQ_OUT_A_OE  = irq_a;
         IRQ_OUT_B_OUT = 1'b0;
         IRQ_OUT_B_OE  = irq_b;
      end else begin
         IRQ_OUT_A_OUT = expander_config_ff[CFG_POLARITY] ? irq_a : ~irq_a;
         IRQ_OUT_A_OE  = 1'b1;
         IRQ_OUT_B_OUT = expander_config_ff[CFG_POLARITY] ? irq_b : ~irq_b;
         IRQ_OUT_B_OE  = 1'b1;
      end
   end

endmodule : pdci_top

// ==== sim/pdci_props.sv ====
// Checker for the port data and change interrupt block
`timescale 1ns/1ps
module pdci_props
   import pdci_pkg::*;
(
   // Clock and register port
   input wire logic       REF_CLK, RST, CLK_EN, REG_WR, REG_RD, REG_RD_DONE, REG_PORT_B,
   input wire logic [3:0] REG_SEL,
   input wire logic [7:0] REG_WDATA, REG_RDATA,
   // Pins and interrupts
   input wire logic [7:0] PORT_A_PINS_IN, PORT_A_PINS_OUT, PORT_A_PINS_OE,
   input wire logic       IRQ_OUT_A_OUT, IRQ_OUT_A_OE, IRQ_OUT_B_OUT, IRQ_OUT_B_OE
);
   logic [7:0] cfg_ff;
   logic       wa, ra, act_a;
   assign wa = CLK_EN && REG_WR && !REG_PORT_B;
   assign ra = CLK_EN && REG_RD && !REG_PORT_B;
   assign act_a = cfg_ff[CFG_OPEN_DRAIN] ? IRQ_OUT_A_OE : (IRQ_OUT_A_OUT == cfg_ff[CFG_POLARITY]);
   // Shadow of the shared config so pin levels can be read as active or idle
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) cfg_ff <= 8'h00;
      else if (CLK_EN && REG_WR && REG_SEL == REG_CONFIG) cfg_ff <= REG_WDATA & CFG_MASK;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   chk_latch_wr: assert property (wa && REG_SEL == REG_OUT_LATCH
      |=> PORT_A_PINS_OUT == $past(REG_WDATA)) else $error("latch write lost");
   chk_pinval_wr: assert property (wa && REG_SEL == REG_PIN_VALUE
      |=> PORT_A_PINS_OUT == $past(REG_WDATA)) else $error("port write missed latch");
   chk_dir_oe: assert property (wa && REG_SEL == REG_PIN_DIR
      |=> PORT_A_PINS_OE == ~$past(REG_WDATA)) else $error("drive enable wrong");
   chk_latch_rd: assert property (ra && REG_SEL == REG_OUT_LATCH
      |=> REG_RDATA == $past(PORT_A_PINS_OUT)) else $error("latch read wrong");
   chk_pin_rd: assert property (ra && REG_SEL == REG_PIN_VALUE
      |=> REG_RDATA == $past(PORT_A_PINS_IN)) else $error("pin read wrong");
   chk_od_low: assert property (cfg_ff[CFG_OPEN_DRAIN]
      |-> !IRQ_OUT_A_OUT && !IRQ_OUT_B_OUT) else $error("open drain drives high");
   chk_pp_drive: assert property (!cfg_ff[CFG_OPEN_DRAIN]
      |-> IRQ_OUT_A_OE && IRQ_OUT_B_OE) else $error("push pull not driven");
   chk_mirror_eq: assert property (cfg_ff[CFG_COMBINE] |-> IRQ_OUT_A_OUT == IRQ_OUT_B_OUT
      && IRQ_OUT_A_OE == IRQ_OUT_B_OE) else $error("combined outputs differ");
   // Config writes change the active level, so they are left out here
   chk_irq_hold: assert property (act_a && !REG_RD_DONE && !$past(REG_RD_DONE)
      && !(REG_WR && REG_SEL == REG_CONFIG) |=> act_a) else $error("interrupt dropped");
   cov_irq_a: cover property (act_a);
   cov_mirror: cover property (cfg_ff[CFG_COMBINE] && act_a);
   cov_clear: cover property (act_a && REG_RD_DONE);
endmodule : pdci_props
bind pdci_top pdci_props i_pdci_props (.REF_CLK, .RST, .CLK_EN, .REG_WR, .REG_RD,
   .REG_RD_DONE, .REG_PORT_B, .REG_SEL, .REG_WDATA, .REG_RDATA, .PORT_A_PINS_IN,
   .PORT_A_PINS_OUT, .PORT_A_PINS_OE, .IRQ_OUT_A_OUT, .IRQ_OUT_A_OE, .IRQ_OUT_B_OUT,
   .IRQ_OUT_B_OE);

// ==== sim/pdci_host.sv ====
// Host model driving the register port of the change interrupt block
`timescale 1ns/1ps
module pdci_host (
   // Clock and read data
   input  wire logic       REF_CLK,
   input  wire logic [7:0] REG_RDATA,
   // Register requests
   output logic            REG_WR, REG_RD, REG_RD_DONE, REG_PORT_B,
   output logic [3:0]      REG_SEL,
   output logic [7:0]      REG_WDATA
);
   initial {REG_WR, REG_RD, REG_RD_DONE, REG_PORT_B, REG_SEL, REG_WDATA} = '0;
   task automatic wr(input logic b, input logic [3:0] s, input logic [7:0] v);
      {REG_PORT_B, REG_SEL, REG_WDATA, REG_WR} = {b, s, v, 1'b1};
      @(posedge REF_CLK) #1;
      REG_WR = 1'b0;
      REG_WDATA = ~v;
   endtask : wr
   task automatic rd(input logic b, input logic [3:0] s, output logic [7:0] v);
      {REG_PORT_B, REG_SEL, REG_RD} = {b, s, 1'b1};
      @(posedge REF_CLK) #1;
      REG_RD = 1'b0;
      @(posedge REF_CLK) #1;
      v = REG_RDATA;
      REG_RD_DONE = 1'b1;
      @(posedge REF_CLK) #1;
      REG_RD_DONE = 1'b0;
   endtask : rd
endmodule : pdci_host

// ==== sim/testbench.sv ====
// Self-checking bench for the port data and change interrupt block
`timescale 1ns/1ps
module testbench;
   import pdci_pkg::*;
   logic       ref_clk = 1'b0, rst = 1'b1, wr, rd, done, psel, ia, iao, ib, ibo, b;
   logic [3:0] sel;
   logic [7:0] pa, pb, d, p1, c, v, wdata, rdata, pin_a, pin_b, a_out, a_oe, b_out, b_oe;
   int         err_total = 0, num_checks = 0;
   // Wire level: the block wins where it drives, the bench elsewhere
   assign pin_a = (a_out & a_oe) | (pa & ~a_oe);
   assign pin_b = (b_out & b_oe) | (pb & ~b_oe);
   always #20 ref_clk = ~ref_clk;
   pdci_top i_pdci_top (.REF_CLK(ref_clk), .RST(rst), .CLK_EN(1'b1), .REG_WR(wr), .REG_RD(rd),
      .REG_RD_DONE(done), .REG_PORT_B(psel), .REG_SEL(sel), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .PORT_A_PINS_IN(pin_a), .PORT_B_PINS_IN(pin_b), .PORT_A_PINS_OUT(a_out),
      .PORT_A_PINS_OE(a_oe), .PORT_B_PINS_OUT(b_out), .PORT_B_PINS_OE(b_oe),
      .IRQ_OUT_A_OUT(ia), .IRQ_OUT_A_OE(iao), .IRQ_OUT_B_OUT(ib), .IRQ_OUT_B_OE(ibo));
   pdci_host i_pdci_host (.REF_CLK(ref_clk), .REG_RDATA(rdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RD_DONE(done), .REG_PORT_B(psel), .REG_SEL(sel), .REG_WDATA(wdata));
   function automatic logic [3:0] lvl(input logic act_a, input logic act_b, input logic [7:0] k);
      return k[CFG_OPEN_DRAIN] ? {act_a, 1'b0, act_b, 1'b0}
         : {1'b1, act_a ~^ k[CFG_POLARITY], 1'b1, act_b ~^ k[CFG_POLARITY]};
   endfunction : lvl
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic rdc(input logic pb_sel, input logic [3:0] s, input logic [7:0] e);
      i_pdci_host.rd(pb_sel, s, d);
      chk(d, e);
   endtask : rdc
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      err_total++;
      report_and_stop;
   end
   initial begin
      pb = 8'h00;
      void'($urandom(47));
      pa = 8'($urandom);
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      rdc(0, REG_PIN_DIR, RST_DIR);
      rdc(1, REG_OUT_LATCH, RST_ZERO);
      chk({iao, ia, ibo, ib}, lvl(0, 0, 8'h00));
      i_pdci_host.wr(0, REG_PIN_DIR, 8'h00);
      i_pdci_host.wr(1, REG_PIN_DIR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         b = i[0];
         v = 8'($urandom);
         i_pdci_host.wr(b, i[1] ? REG_PIN_VALUE : REG_OUT_LATCH, v);
         rdc(b, REG_OUT_LATCH, v);
         rdc(b, REG_PIN_VALUE, v);
      end
      i_pdci_host.wr(0, REG_PIN_DIR, 8'hFF);
      i_pdci_host.wr(1, REG_PIN_DIR, 8'hFF);
      i_pdci_host.wr(0, REG_IRQ_EN, 8'hFF);
      i_pdci_host.wr(1, REG_IRQ_EN, 8'h0F);
      pb = pb ^ 8'hF0;
      tick(3);
      chk({iao, ia, ibo, ib}, lvl(0, 0, 8'h00));
      p1 = pa ^ 8'h10;
      pa = p1;
      tick(3);
      chk({iao, ia, ibo, ib}, lvl(1, 0, 8'h00));
      pa = pa ^ 8'h03;
      tick(3);
      rdc(0, REG_CAPTURE, p1);
      rdc(0, REG_SRC_FLAGS, 8'h10);
      i_pdci_host.wr(0, REG_PIN_VALUE, 8'h55);
      chk({iao, ia, ibo, ib}, lvl(1, 0, 8'h00));
      rdc(0, REG_PIN_VALUE, pa);
      tick(2);
      rdc(0, REG_CAPTURE, pa);
      rdc(0, REG_PIN_VALUE, pa);
      tick(2);
      chk({iao, ia, ibo, ib}, lvl(0, 0, 8'h00));
      c = 8'h01;
      i_pdci_host.wr(0, REG_CONFIG, c);
      pa = pa ^ 8'h80;
      tick(3);
      rdc(0, REG_PIN_VALUE, pa);
      tick(2);
      chk({iao, ia, ibo, ib}, lvl(1, 0, c));
      rdc(0, REG_CAPTURE, pa);
      tick(2);
      chk({iao, ia, ibo, ib}, lvl(0, 0, c));
      c = 8'h42;
      i_pdci_host.wr(0, REG_CONFIG, c);
      i_pdci_host.wr(0, REG_CMP_SRC, 8'hFF);
      i_pdci_host.wr(0, REG_DEF_VAL, pa ^ 8'h01);
      pb = pb ^ 8'h01;
      tick(3);
      chk({iao, ia, ibo, ib}, lvl(1, 1, c));
      rdc(1, REG_PIN_VALUE, pb);
      rdc(0, REG_PIN_VALUE, pa);
      tick(2);
      chk({iao, ia, ibo, ib}, lvl(1, 1, c));
      i_pdci_host.wr(0, REG_DEF_VAL, pa);
      rdc(0, REG_PIN_VALUE, pa);
      tick(2);
      chk({iao, ia, ibo, ib}, lvl(0, 0, c));
      c = 8'h04;
      i_pdci_host.wr(0, REG_CONFIG, c);
      i_pdci_host.wr(0, REG_PIN_DIR, 8'h00);
      i_pdci_host.wr(0, REG_OUT_LATCH, ~pa);
      tick(3);
      chk({iao, ia, ibo, ib}, lvl(0, 0, c));
      report_and_stop;
   end
endmodule : testbench
